// ---- inc/lsu_pkg.sv ----
// Shared types and constants of the load/store execution unit
package lsu_pkg;

  // Command codes delivered by the instruction decoder
  typedef enum logic [3:0] {
    OP_MOVE             = 4'h0,
    OP_PAIR_COPY        = 4'h1,
    OP_LOAD_IMM         = 4'h2,
    OP_PORT_IN          = 4'h3,
    OP_PORT_OUT         = 4'h4,
    OP_INDIRECT_LOAD    = 4'h5,
    OP_INDIRECT_STORE   = 4'h6,
    OP_OFFSET_LOAD      = 4'h7,
    OP_OFFSET_STORE     = 4'h8,
    OP_ABSOLUTE_LOAD    = 4'h9,
    OP_ABSOLUTE_STORE   = 4'ha,
    OP_CODE_MEMORY_READ = 4'hb,
    OP_PUSH             = 4'hc,
    OP_POP              = 4'hd
  } cmd_op_t;

  // Pointer pair select; the pair index is the base with this code appended
  typedef enum logic [1:0] {
    PTR_X = 2'h1,
    PTR_Y = 2'h2,
    PTR_Z = 2'h3
  } ptr_sel_t;

  // Pointer update mode of indirect and code memory accesses
  typedef enum logic [1:0] {
    MODE_PLAIN    = 2'h0,
    MODE_POST_INC = 2'h1,
    MODE_PRE_DEC  = 2'h2
  } ptr_mode_t;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_EXEC   = 4'h2,
    ST_FETCH  = 4'h4,
    ST_ACCESS = 4'h8
  } state_t;

  localparam logic [1:0]  PTR_PAIR_BASE = 2'h3;
  localparam logic [15:0] SP_RESET      = 16'h00ff;
  localparam logic [15:0] PTR_STEP      = 16'h0001;

endpackage

// ---- inc/regfile_if.sv ----
// Ports between the execution unit and its general-purpose register file
`timescale 1ns/1ps
interface regfile_if;
  logic [4:0]  rd_byte_idx;
  logic [7:0]  rd_byte_q;
  logic [3:0]  rd_pair_idx;
  logic [15:0] rd_pair_q;
  logic        wr_byte_en;
  logic [4:0]  wr_byte_idx;
  logic [7:0]  wr_byte_data;
  logic        wr_pair_en;
  logic [3:0]  wr_pair_idx;
  logic [15:0] wr_pair_data;

  modport core (
    output rd_byte_idx, rd_pair_idx, wr_byte_en, wr_byte_idx, wr_byte_data,
    output wr_pair_en, wr_pair_idx, wr_pair_data,
    input  rd_byte_q, rd_pair_q
  );
  modport store (
    input  rd_byte_idx, rd_pair_idx, wr_byte_en, wr_byte_idx, wr_byte_data,
    input  wr_pair_en, wr_pair_idx, wr_pair_data,
    output rd_byte_q, rd_pair_q
  );
endinterface

// ---- rtl/gp_register_file.sv ----
// Thirty-two byte register file with registered byte and pair read ports
`timescale 1ns/1ps
module gp_register_file
  import lsu_pkg::*;
(
  // Clock and reset
  input  wire logic  core_clk,
  input  wire logic  rst_b,
  // Core side
  regfile_if.store   rf
);

  logic [7:0] regs_r [32];

  // Writes; a byte write wins over a pair write on the same byte
  always_ff @(posedge core_clk)
  begin
    if (rf.wr_pair_en)
    begin
      regs_r[{rf.wr_pair_idx, 1'b0}] <= rf.wr_pair_data[7:0];
      regs_r[{rf.wr_pair_idx, 1'b1}] <= rf.wr_pair_data[15:8];
    end
    if (rf.wr_byte_en)
    begin
      regs_r[rf.wr_byte_idx] <= rf.wr_byte_data;
    end
  end

  // Registered reads, old data on a same-edge write
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rf.rd_byte_q <= 8'h00;
      rf.rd_pair_q <= 16'h0000;
    end
    else
    begin
      rf.rd_byte_q <= regs_r[rf.rd_byte_idx];
      rf.rd_pair_q <= {regs_r[{rf.rd_pair_idx, 1'b1}], regs_r[{rf.rd_pair_idx, 1'b0}]};
    end
  end

endmodule

// ---- rtl/load_store_execution_unit.sv ----
// Load/store execution unit: data moves between registers and memories
`timescale 1ns/1ps
// Summary of operation
// - Post-increment load: read, then pointer plus one
// - Pre-decrement load: pointer minus one, then read
// - Offset load reads pointer plus displacement
// - Post-increment store: write, then pointer plus one
// - Pre-decrement store: pointer minus one, then write
// - Offset store writes pointer plus displacement
// - Absolute load reads address from command
// - Absolute store writes address from command
// - Code memory read via Z, three cycles
// - Push writes source to stack, two cycles
// - Pop loads destination from stack, two cycles
module load_store_execution_unit
  import lsu_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Decoded command
  input  wire logic        cmd_valid,
  input  cmd_op_t          cmd_op,
  input  wire logic [4:0]  cmd_dst,
  input  wire logic [4:0]  cmd_src,
  input  ptr_sel_t         cmd_ptr,
  input  ptr_mode_t        cmd_mode,
  input  wire logic [5:0]  cmd_disp,
  input  wire logic [15:0] cmd_addr,
  input  wire logic [7:0]  cmd_imm,
  input  wire logic [5:0]  cmd_port,
  output logic             cmd_ready,
  output logic             done,
  // Data memory, read data valid in the strobe cycle
  output logic [15:0]      dmem_addr,
  output logic [7:0]       dmem_wdata,
  output logic             dmem_we,
  output logic             dmem_re,
  input  wire logic [7:0]  dmem_rdata,
  // Code memory, read data one cycle after the strobe
  output logic [15:0]      pmem_addr,
  output logic             pmem_re,
  input  wire logic [7:0]  pmem_rdata,
  // I/O ports, read data valid in the strobe cycle
  output logic [5:0]       io_addr,
  output logic [7:0]       io_wdata,
  output logic             io_we,
  output logic             io_re,
  input  wire logic [7:0]  io_rdata,
  // Stack pointer
  output logic [15:0]      stack_ptr
);

  regfile_if rf ();

  state_t      state_r;
  state_t      state_nxt;
  cmd_op_t     op_r;
  ptr_mode_t   mode_r;
  logic [4:0]  dst_r;
  logic [3:0]  pair_r;
  logic [5:0]  disp_r;
  logic [15:0] addr_r;
  logic [7:0]  imm_r;
  logic [5:0]  port_r;
  logic [15:0] sp_r;
  logic [15:0] ptr_new_r;
  logic [15:0] acc_addr;
  logic [15:0] ptr_new;
  logic [3:0]  pair_sel;
  logic        take;
  logic        single_op;
  logic        mem_load;
  logic        mem_store;
  logic        ptr_update;
  logic        cmd_ready_r;
  logic        done_r;
  logic [15:0] dmem_addr_r;
  logic [7:0]  dmem_wdata_r;
  logic        dmem_we_r;
  logic        dmem_re_r;
  logic [15:0] pmem_addr_r;
  logic        pmem_re_r;
  logic [5:0]  io_addr_r;
  logic [7:0]  io_wdata_r;
  logic        io_we_r;
  logic        io_re_r;

  gp_register_file u_regs (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .rf       (rf.store)
  );

  // Command classes
  assign take       = cmd_valid && cmd_ready_r;
  assign single_op  = op_r inside {OP_MOVE, OP_PAIR_COPY, OP_LOAD_IMM, OP_PORT_IN, OP_PORT_OUT};
  assign mem_load   = op_r inside {OP_INDIRECT_LOAD, OP_OFFSET_LOAD, OP_ABSOLUTE_LOAD, OP_POP};
  assign mem_store  = op_r inside {OP_INDIRECT_STORE, OP_OFFSET_STORE, OP_ABSOLUTE_STORE, OP_PUSH};
  assign ptr_update = ((op_r inside {OP_INDIRECT_LOAD, OP_INDIRECT_STORE}) && mode_r != MODE_PLAIN)
                      || (op_r == OP_CODE_MEMORY_READ && mode_r == MODE_POST_INC);

  // Pointer pair select; code memory reads always use Z
  // pairs from registers
  assign pair_sel = (cmd_op == OP_CODE_MEMORY_READ) ? {PTR_PAIR_BASE, PTR_Z}
                                                    : {PTR_PAIR_BASE, cmd_ptr};

  // Register file reads launched with the command
  always_comb
  begin
    rf.rd_byte_idx = cmd_src;
    rf.rd_pair_idx = (cmd_op == OP_PAIR_COPY) ? cmd_src[4:1] : pair_sel;
  end

  // Access address and new pointer value
  // sixteen-bit wrapping steps
  always_comb
  begin
    ptr_new  = (mode_r == MODE_POST_INC) ? rf.rd_pair_q + PTR_STEP : rf.rd_pair_q - PTR_STEP;
    acc_addr = rf.rd_pair_q;
    case (op_r)
      OP_INDIRECT_LOAD,
      OP_INDIRECT_STORE:   acc_addr = (mode_r == MODE_PRE_DEC) ? ptr_new : rf.rd_pair_q;
      OP_OFFSET_LOAD,
      OP_OFFSET_STORE:     acc_addr = rf.rd_pair_q + {10'h000, disp_r};
      OP_ABSOLUTE_LOAD,
      OP_ABSOLUTE_STORE:   acc_addr = addr_r;
      OP_PUSH:             acc_addr = sp_r;
      OP_POP:              acc_addr = sp_r + PTR_STEP;
      default:             acc_addr = rf.rd_pair_q;
    endcase
  end

  // Sequencer state
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // extra fetch state for code memory
  always_comb
  begin
    case (state_r)
      ST_IDLE:   state_nxt = take ? ST_EXEC : ST_IDLE;
      ST_EXEC:   state_nxt = single_op ? ST_IDLE
                           : (op_r == OP_CODE_MEMORY_READ) ? ST_FETCH : ST_ACCESS;
      ST_FETCH:  state_nxt = ST_ACCESS;
      ST_ACCESS: state_nxt = ST_IDLE;
      default:   state_nxt = ST_IDLE;
    endcase
  end

  // Command fields captured on acceptance
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      op_r   <= OP_MOVE;
      mode_r <= MODE_PLAIN;
      dst_r  <= 5'h00;
      pair_r <= 4'h0;
      disp_r <= 6'h00;
      addr_r <= 16'h0000;
      imm_r  <= 8'h00;
      port_r <= 6'h00;
    end
    else if (take)
    begin
      op_r   <= cmd_op;
      mode_r <= cmd_mode;
      dst_r  <= cmd_dst;
      pair_r <= pair_sel;
      disp_r <= cmd_disp;
      addr_r <= cmd_addr;
      imm_r  <= cmd_imm;
      port_r <= cmd_port;
    end
  end

  // Handshake and completion pulse
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_ready_r <= 1'b1;
      done_r      <= 1'b0;
    end
    else
    begin
      cmd_ready_r <= (state_nxt == ST_IDLE);
      done_r      <= (state_r == ST_EXEC && single_op) || state_r == ST_ACCESS;
    end
  end

  // Data memory strobes, one cycle each
  // data access
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dmem_addr_r  <= 16'h0000;
      dmem_wdata_r <= 8'h00;
      dmem_we_r    <= 1'b0;
      dmem_re_r    <= 1'b0;
    end
    else
    begin
      dmem_we_r <= state_r == ST_EXEC && mem_store;
      dmem_re_r <= state_r == ST_EXEC && mem_load;
      if (state_r == ST_EXEC && (mem_load || mem_store))
      begin
        dmem_addr_r  <= acc_addr;
        dmem_wdata_r <= rf.rd_byte_q;
      end
    end
  end

  // Code memory strobe and pointer/stack bookkeeping
  // stack pointer steps
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pmem_addr_r <= 16'h0000;
      pmem_re_r   <= 1'b0;
      ptr_new_r   <= 16'h0000;
      sp_r        <= SP_RESET;
    end
    else
    begin
      pmem_re_r <= state_r == ST_EXEC && op_r == OP_CODE_MEMORY_READ;
      if (state_r == ST_EXEC)
      begin
        pmem_addr_r <= rf.rd_pair_q;
        ptr_new_r   <= ptr_new;
        if (op_r == OP_PUSH)
          sp_r <= sp_r - PTR_STEP;
        else if (op_r == OP_POP)
          sp_r <= sp_r + PTR_STEP;
      end
    end
  end

  // I/O strobes: read issued on acceptance, write once source is read
  // port accesses
  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      io_addr_r  <= 6'h00;
      io_wdata_r <= 8'h00;
      io_we_r    <= 1'b0;
      io_re_r    <= 1'b0;
    end
    else
    begin
      io_re_r <= take && cmd_op == OP_PORT_IN;
      io_we_r <= state_r == ST_EXEC && op_r == OP_PORT_OUT;
      if (take && cmd_op == OP_PORT_IN)
        io_addr_r <= cmd_port;
      else if (state_r == ST_EXEC && op_r == OP_PORT_OUT)
      begin
        io_addr_r  <= port_r;
        io_wdata_r <= rf.rd_byte_q;
      end
    end
  end

  // Register file write-back
  // one-cycle register results
  always_comb
  begin
    rf.wr_byte_en   = 1'b0;
    rf.wr_byte_idx  = dst_r;
    rf.wr_byte_data = rf.rd_byte_q;
    rf.wr_pair_en   = 1'b0;
    rf.wr_pair_idx  = pair_r;
    rf.wr_pair_data = ptr_new_r;
    if (state_r == ST_EXEC)
    begin
      rf.wr_byte_en   = op_r inside {OP_MOVE, OP_LOAD_IMM, OP_PORT_IN};
      rf.wr_byte_data = (op_r == OP_LOAD_IMM) ? imm_r
                      : (op_r == OP_PORT_IN) ? io_rdata : rf.rd_byte_q;
      rf.wr_pair_en   = op_r == OP_PAIR_COPY;
      rf.wr_pair_idx  = dst_r[4:1];
      rf.wr_pair_data = rf.rd_pair_q;
    end
    else if (state_r == ST_ACCESS)
    begin
      rf.wr_byte_en   = mem_load || op_r == OP_CODE_MEMORY_READ;
      rf.wr_byte_data = (op_r == OP_CODE_MEMORY_READ) ? pmem_rdata : dmem_rdata;
      rf.wr_pair_en   = ptr_update;
    end
  end

  // Outputs straight from flops
  assign cmd_ready  = cmd_ready_r;
  assign done       = done_r;
  assign dmem_addr  = dmem_addr_r;
  assign dmem_wdata = dmem_wdata_r;
  assign dmem_we    = dmem_we_r;
  assign dmem_re    = dmem_re_r;
  assign pmem_addr  = pmem_addr_r;
  assign pmem_re    = pmem_re_r;
  assign io_addr    = io_addr_r;
  assign io_wdata   = io_wdata_r;
  assign io_we      = io_we_r;
  assign io_re      = io_re_r;
  assign stack_ptr  = sp_r;

  // Checks on command timing and addressing
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  chk_postinc_load: assert property (
    take && cmd_op == OP_INDIRECT_LOAD && cmd_mode == MODE_POST_INC |-> ##2
    (dmem_re_r && rf.wr_pair_en && rf.wr_pair_data == $past(rf.rd_pair_q) + PTR_STEP) ##1 done_r)
    else $error("post-increment load wrong");
  chk_predec_load: assert property (
    take && cmd_op == OP_INDIRECT_LOAD && cmd_mode == MODE_PRE_DEC |-> ##2
    (dmem_re_r && dmem_addr_r == $past(rf.rd_pair_q) - PTR_STEP))
    else $error("pre-decrement load address wrong");
  chk_offset_load: assert property (
    take && cmd_op == OP_OFFSET_LOAD |-> ##2
    (dmem_addr_r == $past(rf.rd_pair_q) + {10'h000, $past(cmd_disp, 2)} && !rf.wr_pair_en))
    else $error("offset load wrong");
  chk_postinc_store: assert property (
    take && cmd_op == OP_INDIRECT_STORE && cmd_mode == MODE_POST_INC |-> ##2
    (dmem_we_r && dmem_addr_r == $past(rf.rd_pair_q) && dmem_wdata_r == $past(rf.rd_byte_q)))
    else $error("post-increment store wrong");
  chk_predec_store: assert property (
    take && cmd_op == OP_INDIRECT_STORE && cmd_mode == MODE_PRE_DEC |-> ##2
    (dmem_we_r && dmem_addr_r == rf.wr_pair_data && rf.wr_pair_en))
    else $error("pre-decrement store wrong");
  chk_absolute_load: assert property (
    take && cmd_op == OP_ABSOLUTE_LOAD |-> ##2
    (dmem_re_r && dmem_addr_r == $past(cmd_addr, 2)) ##1 done_r)
    else $error("absolute load wrong");
  chk_code_read: assert property (
    take && cmd_op == OP_CODE_MEMORY_READ |-> ##2 pmem_re_r ##1 !done_r ##1 done_r)
    else $error("code memory read timing wrong");
  chk_push_stack: assert property (
    take && cmd_op == OP_PUSH |-> ##2 (dmem_we_r && dmem_addr_r == $past(sp_r, 2)) ##1 done_r)
    else $error("push wrong");
  chk_pop_stack: assert property (
    take && cmd_op == OP_POP |-> ##2 (dmem_re_r && dmem_addr_r == $past(sp_r, 2) + PTR_STEP))
    else $error("pop address wrong");
  chk_single_cycle: assert property (
    take && (cmd_op inside {OP_MOVE, OP_PAIR_COPY, OP_LOAD_IMM, OP_PORT_IN, OP_PORT_OUT})
    |-> ##1 !done_r ##1 done_r)
    else $error("single-cycle command late");

  cov_code_read: cover property (take && cmd_op == OP_CODE_MEMORY_READ);
  cov_push_pop: cover property (take && cmd_op == OP_PUSH ##[1:8] take && cmd_op == OP_POP);
  cov_postinc: cover property (take && cmd_op == OP_INDIRECT_LOAD && cmd_mode == MODE_POST_INC);
  cov_back_to_back: cover property (done_r && take);

endmodule

// ---- testbench/mem_model.sv ----
// Data, code and port memory model facing the execution unit
`timescale 1ns/1ps
module mem_model (
  // Clock
  input  wire logic        core_clk,
  // Data memory
  input  wire logic [15:0] dmem_addr,
  input  wire logic [7:0]  dmem_wdata,
  input  wire logic        dmem_we,
  input  wire logic        dmem_re,
  output logic [7:0]       dmem_rdata,
  // Code memory
  input  wire logic [15:0] pmem_addr,
  input  wire logic        pmem_re,
  output logic [7:0]       pmem_rdata,
  // I/O ports
  input  wire logic [5:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_we,
  input  wire logic        io_re,
  output logic [7:0]       io_rdata
);
  logic [7:0] dmem [0:65535];
  logic [7:0] io_regs [0:63];
  logic [7:0] d_last  = 8'h00;
  logic [7:0] p_q     = 8'h00;
  logic [7:0] io_last = 8'h00;
  logic       p_vld   = 1'b0;

  // Read data only in its valid cycle, inverted last value otherwise
  assign dmem_rdata = dmem_re ? dmem[dmem_addr] : ~d_last;
  assign pmem_rdata = p_vld ? p_q : ~p_q;
  assign io_rdata   = io_re ? ({2'h0, io_addr} ^ 8'ha5) : ~io_last;

  // Writes, code byte one cycle after its strobe, held-value tracking
  always @(posedge core_clk)
  begin
    if (dmem_we)
      dmem[dmem_addr] <= dmem_wdata;
    if (dmem_re)
      d_last <= dmem[dmem_addr];
    if (io_we)
      io_regs[io_addr] <= io_wdata;
    if (io_re)
      io_last <= io_rdata;
    p_vld <= pmem_re;
    if (pmem_re)
      p_q <= pmem_addr[7:0] ^ pmem_addr[15:8] ^ 8'h5a;
  end
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench of the load/store execution unit
`timescale 1ns/1ps
module tb_top
  import lsu_pkg::*;
;
  logic        core_clk, rst_b, cmd_valid, cmd_ready, done;
  cmd_op_t     cmd_op;
  ptr_sel_t    cmd_ptr;
  ptr_mode_t   cmd_mode;
  logic [4:0]  cmd_dst, cmd_src;
  logic [5:0]  cmd_disp, cmd_port, io_addr;
  logic [15:0] cmd_addr, dmem_addr, pmem_addr, stack_ptr;
  logic [7:0]  cmd_imm, dmem_wdata, dmem_rdata, pmem_rdata, io_wdata, io_rdata;
  logic        dmem_we, dmem_re, pmem_re, io_we, io_re;
  int          mismatches;
  int          samples_checked;

  load_store_execution_unit i_load_store_execution_unit (.core_clk, .rst_b, .cmd_valid,
    .cmd_op, .cmd_dst, .cmd_src, .cmd_ptr, .cmd_mode, .cmd_disp, .cmd_addr, .cmd_imm,
    .cmd_port, .cmd_ready, .done, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re,
    .dmem_rdata, .pmem_addr, .pmem_re, .pmem_rdata, .io_addr, .io_wdata, .io_we,
    .io_re, .io_rdata, .stack_ptr);
  mem_model i_mem_model (.core_clk, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re,
    .dmem_rdata, .pmem_addr, .pmem_re, .pmem_rdata, .io_addr, .io_wdata, .io_we,
    .io_re, .io_rdata);

  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Offer one command, return cycles from take to done
  task automatic cmd(input cmd_op_t op, input logic [4:0] d, input logic [4:0] s,
                     input ptr_sel_t p, input ptr_mode_t m, input logic [15:0] a,
                     output int k);
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op    <= op;
    cmd_dst   <= d;
    cmd_src   <= s;
    cmd_ptr   <= p;
    cmd_mode  <= m;
    cmd_addr  <= a;
    cmd_disp  <= a[5:0];
    cmd_imm   <= a[7:0];
    cmd_port  <= a[5:0];
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    k = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      k++;
    end
    while (done !== 1'b1 && k < 8);
  endtask

  // Register load and register readback through an absolute store
  task automatic ldi(input logic [4:0] r, input logic [7:0] v);
    int k;
    cmd(OP_LOAD_IMM, r, 5'h00, PTR_X, MODE_PLAIN, {8'h00, v}, k);
    check(16'(k), 16'h0001, "imm cycles");
  endtask
  task automatic peek(input logic [4:0] r, input logic [7:0] e);
    int k;
    cmd(OP_ABSOLUTE_STORE, 5'h00, r, PTR_X, MODE_PLAIN, 16'h0200, k);
    check(16'(k), 16'h0002, "abs store cycles");
    check({8'h00, i_mem_model.dmem[16'h0200]}, {8'h00, e}, "reg");
  endtask
  task automatic setp(input ptr_sel_t p, input logic [15:0] v);
    ldi({PTR_PAIR_BASE, p, 1'b0}, v[7:0]);
    ldi({PTR_PAIR_BASE, p, 1'b1}, v[15:8]);
  endtask
  task automatic peekp(input ptr_sel_t p, input logic [15:0] e);
    peek({PTR_PAIR_BASE, p, 1'b0}, e[7:0]);
    peek({PTR_PAIR_BASE, p, 1'b1}, e[15:8]);
  endtask

  // Every pointer with every mode, loads then stores, wrap at both ends
  task automatic s_indirect;
    ptr_sel_t p;
    ptr_mode_t m;
    logic [15:0] b, a, e;
    logic [7:0] v;
    int k;
    for (int i = 0; i < 9; i++)
    begin
      p = ptr_sel_t'(i / 3 + 1);
      m = ptr_mode_t'(i % 3);
      b = (i == 1) ? 16'hffff : (i == 5) ? 16'h0000 : 16'h0100 + 16'(i * 7);
      a = (m == MODE_PRE_DEC) ? b - 16'h0001 : b;
      e = (m == MODE_PLAIN) ? b : (m == MODE_POST_INC) ? b + 16'h0001 : a;
      v = 8'h30 + 8'(i);
      setp(p, b);
      i_mem_model.dmem[a] = v;
      cmd(OP_INDIRECT_LOAD, 5'd2, 5'd0, p, m, 16'h0000, k);
      check(16'(k), 16'h0002, "load cycles");
      peek(5'd2, v);
      peekp(p, e);
      setp(p, b);
      ldi(5'd3, ~v);
      cmd(OP_INDIRECT_STORE, 5'd0, 5'd3, p, m, 16'h0000, k);
      check(16'(k), 16'h0002, "store cycles");
      check({8'h00, i_mem_model.dmem[a]}, {8'h00, ~v}, "store data");
      peekp(p, e);
    end
  endtask

  // Displacement with wrap, absolute load, code memory read
  task automatic s_offset_code;
    int k;
    setp(PTR_Z, 16'hffe0);
    i_mem_model.dmem[16'h001f] = 8'h6c;
    cmd(OP_OFFSET_LOAD, 5'd4, 5'd0, PTR_Z, MODE_PLAIN, 16'h003f, k);
    check(16'(k), 16'h0002, "offset load cycles");
    peek(5'd4, 8'h6c);
    peekp(PTR_Z, 16'hffe0);
    setp(PTR_Y, 16'h0300);
    cmd(OP_OFFSET_STORE, 5'd0, 5'd4, PTR_Y, MODE_PLAIN, 16'h0021, k);
    check(16'(k), 16'h0002, "offset store cycles");
    check({8'h00, i_mem_model.dmem[16'h0321]}, 16'h006c, "offset store data");
    peekp(PTR_Y, 16'h0300);
    i_mem_model.dmem[16'h0456] = 8'hc3;
    cmd(OP_ABSOLUTE_LOAD, 5'd5, 5'd0, PTR_X, MODE_PLAIN, 16'h0456, k);
    check(16'(k), 16'h0002, "abs load cycles");
    peek(5'd5, 8'hc3);
    setp(PTR_Z, 16'h1234);
    cmd(OP_CODE_MEMORY_READ, 5'd0, 5'd0, PTR_Z, MODE_PLAIN, 16'h0000, k);
    check(16'(k), 16'h0003, "code cycles");
    peek(5'd0, 8'h7c);
    cmd(OP_CODE_MEMORY_READ, 5'd6, 5'd0, PTR_Z, MODE_POST_INC, 16'h0000, k);
    check(16'(k), 16'h0003, "code inc cycles");
    peek(5'd6, 8'h7c);
    peekp(PTR_Z, 16'h1235);
  endtask

  // Two pushes, two pops in reverse, then the one-cycle moves and ports
  task automatic s_stack_fast;
    int k;
    ldi(5'd2, 8'h11);
    ldi(5'd3, 8'h22);
    cmd(OP_PUSH, 5'd0, 5'd2, PTR_X, MODE_PLAIN, 16'h0000, k);
    check(16'(k), 16'h0002, "push cycles");
    check({8'h00, i_mem_model.dmem[16'h00ff]}, 16'h0011, "push data");
    check(stack_ptr, 16'h00fe, "push sp");
    cmd(OP_PUSH, 5'd0, 5'd3, PTR_X, MODE_PLAIN, 16'h0000, k);
    cmd(OP_POP, 5'd6, 5'd0, PTR_X, MODE_PLAIN, 16'h0000, k);
    check(16'(k), 16'h0002, "pop cycles");
    peek(5'd6, 8'h22);
    cmd(OP_POP, 5'd7, 5'd0, PTR_X, MODE_PLAIN, 16'h0000, k);
    peek(5'd7, 8'h11);
    check(stack_ptr, SP_RESET, "pop sp");
    cmd(OP_MOVE, 5'd6, 5'd2, PTR_X, MODE_PLAIN, 16'h0000, k);
    check(16'(k), 16'h0001, "mov cycles");
    peek(5'd6, 8'h11);
    cmd(OP_PAIR_COPY, 5'd8, 5'd2, PTR_X, MODE_PLAIN, 16'h0000, k);
    check(16'(k), 16'h0001, "copy cycles");
    peek(5'd8, 8'h11);
    peek(5'd9, 8'h22);
    cmd(OP_PORT_IN, 5'd7, 5'd0, PTR_X, MODE_PLAIN, 16'h0005, k);
    check(16'(k), 16'h0001, "in cycles");
    peek(5'd7, 8'ha0);
    cmd(OP_PORT_OUT, 5'd0, 5'd3, PTR_X, MODE_PLAIN, 16'h0009, k);
    check(16'(k), 16'h0001, "out cycles");
    @(posedge core_clk);
    #1;
    check({8'h00, i_mem_model.io_regs[9]}, 16'h0022, "out data");
  endtask

  // Counts and verdict, end of run
  task automatic results;
    $display("checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Clock
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Reset, then the scenarios
  initial
  begin
    mismatches = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = OP_MOVE;
    cmd_ptr = PTR_X;
    cmd_mode = MODE_PLAIN;
    {cmd_dst, cmd_src, cmd_disp, cmd_port} = '0;
    {cmd_addr, cmd_imm} = '0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    #1;
    check({15'h0, cmd_ready}, 16'h0001, "ready");
    check(stack_ptr, SP_RESET, "sp reset");
    s_stack_fast();
    s_indirect();
    s_offset_code();
    results();
  end

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    results();
  end
endmodule
